// >>> inc/ebc_pkg.sv
// Contract
// RULE_01: Bus control loads C6 on reset/standby
// RULE_02: Different-area read pair gets one idle
// RULE_03: Read then write gets one idle
// RULE_04: Burst ROM enable makes area 0 burst
// RULE_05: Burst cycle is 2 or 3 states
// RULE_06: Burst max 4 or 8 words
// RULE_07: Map select picks one of two maps
// RULE_08: Map select ignored in mode 6
// RULE_09: Area division only in modes 3-5
// RULE_10: Area division sets area sizes
// RULE_11: Software keeps division set while map cleared
// RULE_12: Wait pin enable lets wait pin stall
// RULE_13: Chip select enable loads 0F on reset/standby
// RULE_14: Enable bits 7-4 force chip select pins
// RULE_15: Chip select writes ignored in single-chip
// RULE_16: Low chip select bits read one
// RULE_17: New settings apply at next bus cycle
package ebc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register map, byte addresses on the Wishbone port
    localparam logic [7:0] OFS_BUS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CS_EN = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;

    // Reset values
    localparam logic [7:0] BUS_CTRL_RESET = 8'hC6;
    localparam logic [7:0] CS_EN_RESET = 8'h0F;

    // Bus control field positions
    localparam int BIT_IDLE_DIFF = 7;
    localparam int BIT_IDLE_RW = 6;
    localparam int BIT_BROM = 5;
    localparam int BIT_BLEN = 4;
    localparam int BIT_BWORDS = 3;
    localparam int BIT_MMAP = 2;
    localparam int BIT_ADIV = 1;
    localparam int BIT_WAIT_PIN_ENABLE = 0;

    // Chip select enable field: bits 7..4, low nibble reserved
    localparam int CS_EN_LSB = 4;
    localparam int CS_EN_W = 4;
    localparam logic [3:0] CS_RSVD_VAL = 4'hF;

    // Status register field positions
    localparam int ST_MODE_LSB = 0;
    localparam int ST_MAP_BIT = 3;
    localparam int ST_DIV_BIT = 4;
    localparam int ST_WAIT_BIT = 5;
    localparam int ST_AREA_LSB = 6;

    ////////////////////////////////////////////////////////////////////////
    // Operating modes
    localparam logic [2:0] MODE_MAP_FIXED = 3'h6;
    localparam logic [2:0] MODE_DIV_LO = 3'h3;
    localparam logic [2:0] MODE_DIV_HI = 3'h5;
    localparam logic [2:0] MODE_SINGLE_LO = 3'h6;

    // Burst ROM figures
    localparam logic [1:0] BURST_STATES_SHORT = 2'h2;
    localparam logic [1:0] BURST_STATES_LONG = 2'h3;
    localparam logic [3:0] BURST_WORDS_FEW = 4'h4;
    localparam logic [3:0] BURST_WORDS_MANY = 4'h8;
    localparam int BURST_LSB_FEW = 4;
    localparam int BURST_LSB_MANY = 5;

    // Area bases, uneven division
    localparam int ADDR_W = 24;
    localparam int AREA_UNIT_LSB = 21;
    localparam logic [23:0] AREA1_BASE = 24'h200000;
    localparam logic [23:0] AREA2_BASE = 24'h400000;
    localparam logic [23:0] AREA3_BASE = 24'hC00000;
    localparam logic [23:0] AREA4_BASE = 24'hE00000;
    localparam logic [23:0] AREA5_BASE = 24'hFF90EA;
    localparam logic [23:0] AREA6_BASE = 24'hFFA0EA;
    localparam logic [23:0] AREA7_BASE = 24'hFFFFEA;

    ////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic valid;
        logic busy;
        logic write;
        logic [23:0] addr;
    } ebc_req_t;

    typedef struct packed {
        logic valid;
        logic [2:0] area;
        logic idle_before;
        logic burst_area;
        logic [1:0] burst_states;
        logic [3:0] burst_words;
        logic burst_hit;
    } ebc_info_t;

    typedef struct packed {
        logic [3:0] cs_out_en;
        logic wait_pin_func;
        logic wait_stall;
        logic mem_map;
        logic area_div;
    } ebc_pins_t;

endpackage

// >>> logic/ebc_area_dec.sv
`timescale 1ns/10ps
`default_nettype none
module ebc_area_dec #(
    parameter int ADDR_W = 24
) (
    input wire logic [ADDR_W-1:0] addr,
    input wire logic uniform,
    output logic [2:0] area
);

    ////////////////////////////////////////////////////////////////////////
    // Area bases are fixed to a 16 Mbyte space
    generate
        if (ADDR_W != ebc_pkg::ADDR_W) begin : g_bad_width
            $error("ebc_area_dec supports only a 24-bit address");
        end
    endgenerate

    // Uniform 2 Mbyte slices, or the uneven table
    always_comb begin
        area = 3'h0;
        if (uniform) begin
            area = addr[ADDR_W-1:ebc_pkg::AREA_UNIT_LSB]; // RULE_10
        end else if (addr >= ebc_pkg::AREA7_BASE) begin
            area = 3'h7; // RULE_10
        end else if (addr >= ebc_pkg::AREA6_BASE) begin
            area = 3'h6;
        end else if (addr >= ebc_pkg::AREA5_BASE) begin
            area = 3'h5;
        end else if (addr >= ebc_pkg::AREA4_BASE) begin
            area = 3'h4;
        end else if (addr >= ebc_pkg::AREA3_BASE) begin
            area = 3'h3;
        end else if (addr >= ebc_pkg::AREA2_BASE) begin
            area = 3'h2;
        end else if (addr >= ebc_pkg::AREA1_BASE) begin
            area = 3'h1;
        end
    end

endmodule
`default_nettype wire

// >>> logic/ebc_config.sv
`timescale 1ns/10ps
`default_nettype none
module ebc_config (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic [2:0] MODE,
    input wire logic HW_STANDBY_N,
    input wire logic WAIT_N,
    input wire ebc_pkg::ebc_req_t REQ,
    output ebc_pkg::ebc_info_t INFO,
    output ebc_pkg::ebc_pins_t PINS
);

    ////////////////////////////////////////////////////////////////////////
    // Whole state of the block
    typedef struct packed {
        logic [2:0] mode_s1;
        logic [2:0] mode_s2;
        logic [2:0] mode_s3;
        logic [2:0] mode_q;
        logic stby_s1;
        logic stby_s2;
        logic stby_s3;
        logic stby_q;
        logic wait_s1;
        logic wait_s2;
        logic wait_s3;
        logic wait_q;
        logic [7:0] bus_ctrl;
        logic [3:0] cs_en;
        logic ack;
        logic [31:0] dat;
        logic prev_valid;
        logic prev_read;
        logic [2:0] prev_area;
        logic [23:0] prev_addr;
        ebc_pkg::ebc_info_t info;
        ebc_pkg::ebc_pins_t pins;
    } ebc_state_t;

    ebc_state_t st_reg;
    ebc_state_t st_next;

    logic access;
    logic wr_ok;
    logic single_chip;
    logic div_valid;
    logic eff_div;
    logic eff_map;
    logic [2:0] req_area;
    logic diff_area;
    logic hit_few;
    logic hit_many;
    logic burst_on;

    ////////////////////////////////////////////////////////////////////////
    // Mode-derived qualifiers, all from filtered pins
    always_comb begin
        single_chip = (st_reg.mode_q >= ebc_pkg::MODE_SINGLE_LO);
        div_valid = (st_reg.mode_q >= ebc_pkg::MODE_DIV_LO)
            && (st_reg.mode_q <= ebc_pkg::MODE_DIV_HI);
        // Outside modes 3-5 the bit is don't-care: behave as uniform
        eff_div = div_valid ? st_reg.bus_ctrl[ebc_pkg::BIT_ADIV] : 1'b1; // RULE_09
        // Mode 6 pins the default map whatever software wrote
        if (st_reg.mode_q == ebc_pkg::MODE_MAP_FIXED) begin
            eff_map = 1'b1; // RULE_08
        end else begin
            eff_map = st_reg.bus_ctrl[ebc_pkg::BIT_MMAP]; // RULE_07
        end
    end

    // Area of the cycle now starting, from live settings
    ebc_area_dec #(
        .ADDR_W(ebc_pkg::ADDR_W)
    ) u_area (
        .addr(REQ.addr),
        .uniform(eff_div),
        .area(req_area)
    );

    // Burst neighbourhood compare against the previous address
    always_comb begin
        diff_area = (req_area != st_reg.prev_area);
        hit_few = (REQ.addr[23:ebc_pkg::BURST_LSB_FEW]
            == st_reg.prev_addr[23:ebc_pkg::BURST_LSB_FEW]);
        hit_many = (REQ.addr[23:ebc_pkg::BURST_LSB_MANY]
            == st_reg.prev_addr[23:ebc_pkg::BURST_LSB_MANY]);
        burst_on = st_reg.bus_ctrl[ebc_pkg::BIT_BROM];
        access = WB_CYC_I && WB_STB_I && !st_reg.ack;
        wr_ok = access && WB_WE_I && WB_SEL_I[0];
    end

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        st_next = st_reg;
        st_next.ack = 1'b0;
        st_next.info.valid = 1'b0;

        // Pin filters: a change counts once stages two and three agree
        st_next.mode_s1 = MODE;
        st_next.mode_s2 = st_reg.mode_s1;
        st_next.mode_s3 = st_reg.mode_s2;
        if (st_reg.mode_s2 == st_reg.mode_s3) begin
            st_next.mode_q = st_reg.mode_s3;
        end
        st_next.stby_s1 = HW_STANDBY_N;
        st_next.stby_s2 = st_reg.stby_s1;
        st_next.stby_s3 = st_reg.stby_s2;
        if (st_reg.stby_s2 == st_reg.stby_s3) begin
            st_next.stby_q = st_reg.stby_s3;
        end
        st_next.wait_s1 = WAIT_N;
        st_next.wait_s2 = st_reg.wait_s1;
        st_next.wait_s3 = st_reg.wait_s2;
        if (st_reg.wait_s2 == st_reg.wait_s3) begin
            st_next.wait_q = st_reg.wait_s3;
        end

        // Wishbone slave: one-cycle answer, unmapped reads zero
        if (access) begin
            st_next.ack = 1'b1;
            st_next.dat = 32'h00000000;
            case (WB_ADR_I)
                ebc_pkg::OFS_BUS_CTRL: begin
                    st_next.dat[7:0] = st_reg.bus_ctrl;
                    if (wr_ok) begin
                        st_next.bus_ctrl = WB_DAT_I[7:0];
                    end
                end
                ebc_pkg::OFS_CS_EN: begin
                    // Reserved nibble is constant ones
                    st_next.dat[7:0] = {st_reg.cs_en,
                        ebc_pkg::CS_RSVD_VAL}; // RULE_16
                    if (wr_ok && !single_chip) begin // RULE_15
                        st_next.cs_en = WB_DAT_I[7:ebc_pkg::CS_EN_LSB];
                    end
                end
                ebc_pkg::OFS_STATUS: begin
                    st_next.dat[ebc_pkg::ST_MODE_LSB +: 3] = st_reg.mode_q;
                    st_next.dat[ebc_pkg::ST_MAP_BIT] = eff_map;
                    st_next.dat[ebc_pkg::ST_DIV_BIT] = eff_div;
                    st_next.dat[ebc_pkg::ST_WAIT_BIT] = st_reg.wait_q;
                    st_next.dat[ebc_pkg::ST_AREA_LSB +: 3] =
                        st_reg.prev_area;
                end
                default: begin
                    st_next.dat = 32'h00000000;
                end
            endcase
        end

        // Hardware standby forces defaults; software standby is not seen
        if (!st_reg.stby_q) begin
            st_next.bus_ctrl = ebc_pkg::BUS_CTRL_RESET; // RULE_01
            st_next.cs_en =
                ebc_pkg::CS_EN_RESET[7:ebc_pkg::CS_EN_LSB]; // RULE_13
        end

        // Per-cycle attributes, latched at the start of a bus cycle
        if (REQ.valid) begin
            st_next.info.valid = 1'b1;
            st_next.info.area = req_area;
            // Idle only between two adjacent cycles led by a read
            st_next.info.idle_before = st_reg.prev_valid
                && st_reg.prev_read
                && ((!REQ.write && diff_area
                    && st_reg.bus_ctrl[ebc_pkg::BIT_IDLE_DIFF]) // RULE_02
                || (REQ.write
                    && st_reg.bus_ctrl[ebc_pkg::BIT_IDLE_RW])); // RULE_03
            st_next.info.burst_area = burst_on
                && (req_area == 3'h0); // RULE_04
            if (st_reg.bus_ctrl[ebc_pkg::BIT_BLEN]) begin
                st_next.info.burst_states =
                    ebc_pkg::BURST_STATES_LONG; // RULE_05
            end else begin
                st_next.info.burst_states = ebc_pkg::BURST_STATES_SHORT;
            end
            // Burst continues only inside the same aligned word group
            if (st_reg.bus_ctrl[ebc_pkg::BIT_BWORDS]) begin
                st_next.info.burst_words = ebc_pkg::BURST_WORDS_MANY;
                st_next.info.burst_hit = hit_many; // RULE_06
            end else begin
                st_next.info.burst_words = ebc_pkg::BURST_WORDS_FEW;
                st_next.info.burst_hit = hit_few; // RULE_06
            end
            st_next.info.burst_hit = st_next.info.burst_hit
                && burst_on && !REQ.write && st_reg.prev_valid
                && st_reg.prev_read && (st_reg.prev_area == 3'h0)
                && (req_area == 3'h0);
            st_next.prev_valid = 1'b1;
            st_next.prev_read = !REQ.write;
            st_next.prev_area = req_area;
            st_next.prev_addr = REQ.addr;
        end

        // Pin functions change only between cycles, never mid-cycle
        if (REQ.valid || !REQ.busy) begin // RULE_17
            st_next.pins.cs_out_en = st_reg.cs_en; // RULE_14
            st_next.pins.wait_pin_func =
                st_reg.bus_ctrl[ebc_pkg::BIT_WAIT_PIN_ENABLE]; // RULE_12
            st_next.pins.mem_map = eff_map;
            st_next.pins.area_div = eff_div;
        end

        // Wait pin is active low; gated by the pin function it is
        // registered with, so a stall never outlives its enable
        st_next.pins.wait_stall = st_next.pins.wait_pin_func
            && !st_reg.wait_q; // RULE_12
    end

    ////////////////////////////////////////////////////////////////////////
    // State register, synchronous reset to constants only
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            st_reg <= '0;
            st_reg.stby_s1 <= 1'b1;
            st_reg.stby_s2 <= 1'b1;
            st_reg.stby_s3 <= 1'b1;
            st_reg.stby_q <= 1'b1;
            st_reg.wait_s1 <= 1'b1;
            st_reg.wait_s2 <= 1'b1;
            st_reg.wait_s3 <= 1'b1;
            st_reg.wait_q <= 1'b1;
            st_reg.bus_ctrl <= ebc_pkg::BUS_CTRL_RESET; // RULE_01
            st_reg.cs_en <=
                ebc_pkg::CS_EN_RESET[7:ebc_pkg::CS_EN_LSB]; // RULE_13
            st_reg.pins.mem_map <= 1'b1;
            st_reg.pins.area_div <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state flops
    assign WB_DAT_O = st_reg.dat;
    assign WB_ACK_O = st_reg.ack;
    assign INFO = st_reg.info;
    assign PINS = st_reg.pins;

endmodule
`default_nettype wire

// >>> verification/ebc_config_chk.sv
`timescale 1ns/10ps
`default_nettype none
module ebc_config_chk (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    input wire ebc_pkg::ebc_req_t REQ,
    input wire ebc_pkg::ebc_info_t INFO,
    input wire ebc_pkg::ebc_pins_t PINS
);
    // One clock domain, so clocking and reset are shared
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    ////////////////////////////////////////////////////////////////////////
    // Register port
    ack_one_shot_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O
        |=> WB_ACK_O ##1 !WB_ACK_O) else $error("ack not one late pulse");
    upper_zero_a: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0)
        else $error("read data upper bits set");
    rsvd_ones_a: assert property (
        WB_ACK_O && !WB_WE_I && WB_ADR_I == ebc_pkg::OFS_CS_EN
        |-> WB_DAT_O[3:0] == 4'hF) else $error("reserved bits not one");

    ////////////////////////////////////////////////////////////////////////
    // Bus cycle port
    info_late_a: assert property (REQ.valid |=> INFO.valid)
        else $error("cycle info missing");
    info_cause_a: assert property (INFO.valid |-> $past(REQ.valid))
        else $error("cycle info without request");
    brom_area_a: assert property (INFO.valid && INFO.area != 3'h0
        |-> !INFO.burst_area && !INFO.burst_hit) else $error("burst off area 0");
    burst_len_a: assert property (INFO.valid
        |-> INFO.burst_states inside {2'h2, 2'h3}) else $error("burst states");
    burst_words_a: assert property (INFO.valid
        |-> INFO.burst_words inside {4'h4, 4'h8}) else $error("burst words");
    hit_on_read_a: assert property (INFO.valid && $past(REQ.write)
        |-> !INFO.burst_hit) else $error("burst hit on write");
    wait_gate_a: assert property (PINS.wait_stall
        |-> PINS.wait_pin_func) else $error("stall with wait pin off");
    pins_frozen_a: assert property (REQ.busy && !REQ.valid
        |=> $stable(PINS.cs_out_en) && $stable(PINS.wait_pin_func))
        else $error("pins changed in mid cycle");
endmodule

bind ebc_config ebc_config_chk ebc_config_chk_i (.CORE_CLK, .RST_N,
    .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_DAT_O, .WB_ACK_O,
    .REQ, .INFO, .PINS);
`default_nettype wire

// >>> verification/ebc_config_tb.sv
`timescale 1ns/10ps
`default_nettype none
module ebc_config_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic [2:0] mode = 3'h4;
    logic stby_n = 1'b1;
    logic stall = 1'b0;
    logic [31:0] rdat;
    logic [31:0] q;
    logic ack;
    logic wait_n;
    ebc_pkg::ebc_req_t req;
    ebc_pkg::ebc_info_t info;
    ebc_pkg::ebc_pins_t pins;
    int n_errors = 0;
    int n_tests = 0;
    int cycles = 0;

    // Free running core clock
    always #5 clk = ~clk;

    ebc_config ebc_config_i (.CORE_CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF),
        .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .MODE(mode),
        .HW_STANDBY_N(stby_n), .WAIT_N(wait_n), .REQ(req), .INFO(info),
        .PINS(pins));
    ebc_mem_model ebc_mem_model_i (.clk(clk), .stall(stall), .req(req),
        .wait_n(wait_n));

    ////////////////////////////////////////////////////////////////////////
    // Shared helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Classic cycle held until ack is seen; read data taken at that edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {24'h0, d};
        // Ends on ack; only the bench's hang guard ends a wait that gets no ack
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = rdat;
        chk(32'(ack), 32'h1);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic run(input logic w, input logic [23:0] a);
        ebc_mem_model_i.run(w, a, 3);
    endtask

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset;
        wb(1'b0, 8'h00, 8'h00);
        chk(q, 32'hC6);
        wb(1'b0, 8'h04, 8'h00);
        chk(q, 32'h0F);
        wb(1'b0, 8'h0C, 8'h00);
        chk(q, 32'h0);
        wb(1'b0, 8'h08, 8'h00);
        chk(q, 32'h3C);
        chk(32'(pins.cs_out_en), 32'h0);
    endtask

    task automatic t_csen;
        wb(1'b1, 8'h04, 8'hFF);
        wb(1'b0, 8'h04, 8'h00);
        chk(q, 32'hFF);
        wb(1'b1, 8'h04, 8'h50);
        wb(1'b0, 8'h04, 8'h00);
        chk(q, 32'h5F);
        repeat (2) @(posedge clk);
        chk(32'(pins.cs_out_en), 32'h5);
    endtask

    // Single-chip mode: chip select locked, map and division forced
    task automatic t_single;
        mode <= 3'h6;
        repeat (8) @(posedge clk);
        wb(1'b1, 8'h04, 8'hA0);
        wb(1'b0, 8'h04, 8'h00);
        chk(q, 32'h5F);
        wb(1'b1, 8'h00, 8'hC4);
        wb(1'b1, 8'h00, 8'hC6);
        wb(1'b1, 8'h00, 8'hC2);
        repeat (2) @(posedge clk);
        chk(32'({pins.mem_map, pins.area_div}), 32'h3);
        mode <= 3'h4;
        repeat (8) @(posedge clk);
        chk(32'(pins.mem_map), 32'h0);
        wb(1'b1, 8'h00, 8'hC6);
        wb(1'b1, 8'h00, 8'hC4);
        repeat (2) @(posedge clk);
        chk(32'(pins.area_div), 32'h0);
    endtask

    task automatic t_area;
        run(1'b0, ebc_pkg::AREA5_BASE);
        chk(32'(info.area), 32'h5);
        run(1'b0, ebc_pkg::AREA7_BASE);
        chk(32'(info.area), 32'h7);
        run(1'b0, 24'h700000);
        chk(32'(info.area), 32'h2);
        wb(1'b1, 8'h00, 8'hC6);
        run(1'b0, 24'h700000);
        chk(32'(info.area), 32'h3);
    endtask

    task automatic t_idle;
        run(1'b0, 24'h0);
        run(1'b0, ebc_pkg::AREA1_BASE);
        chk(32'(info.idle_before), 32'h1);
        run(1'b0, ebc_pkg::AREA1_BASE);
        chk(32'(info.idle_before), 32'h0);
        run(1'b1, ebc_pkg::AREA1_BASE);
        chk(32'(info.idle_before), 32'h1);
        wb(1'b1, 8'h00, 8'h06);
        run(1'b0, 24'h0);
        run(1'b0, ebc_pkg::AREA1_BASE);
        chk(32'(info.idle_before), 32'h0);
        run(1'b1, ebc_pkg::AREA1_BASE);
        chk(32'(info.idle_before), 32'h0);
    endtask

    // Burst groups: 0x20 and 0x30 share an 8-word group, not a 4-word one
    task automatic t_burst;
        wb(1'b1, 8'h00, 8'h26);
        run(1'b0, 24'h20);
        chk(32'({info.burst_area, info.burst_states}), 32'h6);
        run(1'b0, 24'h30);
        chk(32'({info.burst_hit, info.burst_words}), 32'h4);
        wb(1'b1, 8'h00, 8'h3E);
        run(1'b0, 24'h20);
        run(1'b0, 24'h30);
        chk(32'({info.burst_states, info.burst_words}), 32'h38);
        chk(32'(info.burst_hit), 32'h1);
        run(1'b0, ebc_pkg::AREA1_BASE);
        chk(32'(info.burst_area), 32'h0);
    endtask

    task automatic t_wait;
        wb(1'b1, 8'h00, 8'hC7);
        stall <= 1'b1;
        repeat (8) @(posedge clk);
        chk(32'({pins.wait_pin_func, pins.wait_stall}), 32'h3);
        wb(1'b1, 8'h00, 8'hC6);
        repeat (8) @(posedge clk);
        chk(32'({pins.wait_pin_func, pins.wait_stall}), 32'h0);
        stall <= 1'b0;
    endtask

    // A write during a bus cycle reaches the pins only once it ends
    task automatic t_freeze;
        fork
            run(1'b0, 24'h0);
            begin
                wb(1'b1, 8'h04, 8'hA0);
                @(posedge clk);
                chk(32'(pins.cs_out_en), 32'h5);
            end
        join
        repeat (2) @(posedge clk);
        chk(32'(pins.cs_out_en), 32'hA);
    endtask

    task automatic t_stby;
        wb(1'b1, 8'h00, 8'h02);
        wb(1'b1, 8'h04, 8'hF0);
        wb(1'b0, 8'h00, 8'h00);
        chk(q, 32'h02);
        stby_n <= 1'b0;
        repeat (8) @(posedge clk);
        stby_n <= 1'b1;
        repeat (8) @(posedge clk);
        wb(1'b0, 8'h00, 8'h00);
        chk(q, 32'hC6);
        wb(1'b0, 8'h04, 8'h00);
        chk(q, 32'h0F);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Hang guard: the whole run needs well under this many cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            summarize();
        end
    end

    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_reset();
        t_csen();
        t_single();
        t_area();
        t_idle();
        t_burst();
        t_wait();
        t_freeze();
        t_stby();
        summarize();
    end
endmodule
`default_nettype wire

// >>> verification/ebc_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module ebc_mem_model (
    input wire logic clk,
    input wire logic stall,
    output ebc_pkg::ebc_req_t req,
    output logic wait_n
);
    // Slow peripheral pulls its wait line low on demand
    assign wait_n = !stall;
    initial req = '0;
    // One bus cycle: start pulse, then busy for n more states
    task automatic run(input logic wr, input logic [23:0] a, input int n);
        @(posedge clk);
        req <= '{valid: 1'b1, busy: 1'b1, write: wr, addr: a};
        @(posedge clk);
        req.valid <= 1'b0;
        repeat (n) @(posedge clk);
        req.busy <= 1'b0;
        req.addr <= ~a; // Released lines stop showing the address
    endtask
endmodule
`default_nettype wire
